// [pkg/phy_counter_pkg.sv]
// constants for the link event counter bank and its log page
`default_nettype none
package phy_counter_pkg;

    localparam int NUM_CNT = 20;
    localparam int REC_W   = 5;

    // identifier layout: vendor flag, size code, event number
    localparam int ID_VENDOR_BIT = 15;
    localparam int ID_SIZE_HI    = 14;
    localparam int ID_SIZE_LO    = 12;

    // size codes carried in the identifier
    localparam logic [2:0] SIZE_16 = 3'h1;
    localparam logic [2:0] SIZE_32 = 3'h2;
    localparam logic [2:0] SIZE_48 = 3'h3;
    localparam logic [2:0] SIZE_64 = 3'h4;

    // reported value width and its size code
    localparam int         REP_W    = 32;
    localparam logic [2:0] REP_SIZE = SIZE_32;

    localparam logic [15:0] ID_END_MARK = 16'h0000;

    // event numbers, slot order = counter index
    localparam logic [11:0] CNT_ID [NUM_CNT] = '{
        12'h001, 12'h002, 12'h003, 12'h004, 12'h005,
        12'h006, 12'h007, 12'h008, 12'h009, 12'h00a,
        12'h00b, 12'h00d, 12'h00f, 12'h010, 12'h012,
        12'h013, 12'hc00, 12'hc01, 12'hc02, 12'h001
    };
    // slot 19 is vendor specific (escaped frames); number is arbitrary
    localparam logic [NUM_CNT-1:0] VENDOR_MASK = 20'h80000;
    localparam logic [NUM_CNT-1:0] MAND_MASK   = 20'h00201;

    // counter slot indices
    localparam int IX_CMD_ICRC   = 0;
    localparam int IX_DATA_ANY   = 1;
    localparam int IX_D2H_DATA   = 2;
    localparam int IX_H2D_DATA   = 3;
    localparam int IX_NDATA_ANY  = 4;
    localparam int IX_D2H_NDATA  = 5;
    localparam int IX_H2D_NDATA  = 6;
    localparam int IX_D2H_RETRY  = 7;
    localparam int IX_PHY_DROP   = 8;
    localparam int IX_SIG_FIS    = 9;
    localparam int IX_H2D_CRC    = 10;
    localparam int IX_H2D_OTHER  = 11;
    localparam int IX_DATA_CRC   = 12;
    localparam int IX_DATA_OTHER = 13;
    localparam int IX_ND_CRC     = 14;
    localparam int IX_ND_OTHER   = 15;
    localparam int IX_PM_COLL    = 16;
    localparam int IX_PM_SIG     = 17;
    localparam int IX_PM_CRC     = 18;
    localparam int IX_ESCAPE     = 19;

    // log page layout
    localparam logic [8:0] HDR_LAST_BYTE = 9'h003;
    localparam logic [8:0] PAD_LAST_BYTE = 9'h1fe;
    localparam logic [8:0] SUM_BYTE      = 9'h1ff;
    localparam logic [2:0] REC_LAST_OFF  = 3'h5;
    localparam int         LOG_CLR_BIT   = 0;

endpackage : phy_counter_pkg
`default_nettype wire

// [design/phy_event_counters.sv]
// link event counter bank with log page readout
`default_nettype none
module phy_event_counters
    import phy_counter_pkg::*;
#(
    parameter int                 CNT_W    = 32,
    parameter logic [NUM_CNT-1:0] OPT_MASK = 20'hfffff
) (
    input  wire logic       REF_CLK,
    input  wire logic       RESET,
    input  wire logic       CMD_DONE,
    input  wire logic       CMD_STATUS_ERR,
    input  wire logic       CMD_ERROR_ICRC,
    input  wire logic       D2H_DATA_RERR,
    input  wire logic       H2D_DATA_RERR_CRC,
    input  wire logic       H2D_DATA_RERR_OTHER,
    input  wire logic       D2H_NDATA_RERR,
    input  wire logic       D2H_NDATA_RETRIED,
    input  wire logic       H2D_NDATA_RERR_CRC,
    input  wire logic       H2D_NDATA_RERR_OTHER,
    input  wire logic       SYNC_ESCAPE,
    input  wire logic       PHY_READY,
    input  wire logic       SIG_FIS_ACKED,
    input  wire logic       PM_COLLISION,
    input  wire logic       PM_SIG_FWD,
    input  wire logic       PM_CRC_CORRUPT,
    input  wire logic       BIST_ACTIVATE,
    input  wire logic       LOG_READ,
    input  wire logic [7:0] LOG_FEATURES,
    output var  logic [7:0] PAGE_BYTE,
    output var  logic       PAGE_VALID,
    output var  logic       PAGE_LAST,
    output var  logic       LOG_BUSY
);

    localparam logic [NUM_CNT-1:0] IMPL = OPT_MASK | MAND_MASK;

    typedef enum logic [2:0] {
        S_IDLE = 3'b000,
        S_HDR  = 3'b001,
        S_REC  = 3'b010,
        S_PAD  = 3'b011,
        S_SUM  = 3'b100
    } page_st_e;

    page_st_e           st_ff;
    logic [8:0]         idx_ff;
    logic [2:0]         off_ff;
    logic [REC_W-1:0]   rec_ff;
    logic [REC_W-1:0]   first_rec;
    logic [REC_W-1:0]   nxt_rec;
    logic [7:0]         sum_ff;
    logic               clr_req_ff;
    logic               phy_rdy_ff;
    logic [CNT_W-1:0]   cnt_ff  [NUM_CNT];
    logic [CNT_W-1:0]   snap_ff [NUM_CNT];
    logic [NUM_CNT-1:0] inc;
    logic               err_ok;
    logic               h2d_data;
    logic               h2d_nd;
    logic               start;
    logic               clr_page;
    logic               clr_all;
    logic [15:0]        rec_id;
    logic [REP_W-1:0]   rec_val;
    logic [7:0]         cur_byte;

    // first built slot at or after a given one, NUM_CNT if none
    function automatic logic [REC_W-1:0] next_impl(
        input logic [REC_W-1:0] from
    );
        logic [REC_W-1:0] res;
        res = REC_W'(NUM_CNT);
        for (int i = NUM_CNT - 1; i >= 0; i--) begin
            if (IMPL[i] && (REC_W'(i) >= from)) begin
                res = REC_W'(i);
            end
        end
        return res;
    endfunction : next_impl

    assign first_rec = next_impl('0);
    assign nxt_rec   = next_impl(rec_ff + REC_W'(1));

    assign err_ok   = ~SYNC_ESCAPE;
    assign h2d_data = (H2D_DATA_RERR_CRC | H2D_DATA_RERR_OTHER) & err_ok;
    assign h2d_nd   = (H2D_NDATA_RERR_CRC | H2D_NDATA_RERR_OTHER) & err_ok;

    always_comb begin
        inc = '0;
        inc[IX_CMD_ICRC]   = CMD_DONE & CMD_STATUS_ERR & CMD_ERROR_ICRC;
        inc[IX_DATA_ANY]   = (D2H_DATA_RERR & err_ok) | h2d_data;
        inc[IX_D2H_DATA]   = D2H_DATA_RERR & err_ok;
        inc[IX_H2D_DATA]   = h2d_data;
        // non-data, each retry a new strobe
        inc[IX_NDATA_ANY]  = (D2H_NDATA_RERR & err_ok) | h2d_nd;
        inc[IX_D2H_NDATA]  = D2H_NDATA_RERR & err_ok;
        inc[IX_H2D_NDATA]  = h2d_nd;
        inc[IX_D2H_RETRY]  = D2H_NDATA_RERR & D2H_NDATA_RETRIED & err_ok;
        inc[IX_PHY_DROP]   = phy_rdy_ff & ~PHY_READY;
        inc[IX_SIG_FIS]    = SIG_FIS_ACKED;
        inc[IX_H2D_CRC]    = (H2D_DATA_RERR_CRC | H2D_NDATA_RERR_CRC)
                             & err_ok;
        inc[IX_H2D_OTHER]  = (H2D_DATA_RERR_OTHER | H2D_NDATA_RERR_OTHER)
                             & err_ok;
        inc[IX_DATA_CRC]   = H2D_DATA_RERR_CRC & err_ok;
        inc[IX_DATA_OTHER] = H2D_DATA_RERR_OTHER & err_ok;
        inc[IX_ND_CRC]     = H2D_NDATA_RERR_CRC & err_ok;
        inc[IX_ND_OTHER]   = H2D_NDATA_RERR_OTHER & err_ok;
        inc[IX_PM_COLL]    = PM_COLLISION & err_ok;
        inc[IX_PM_SIG]     = PM_SIG_FWD;
        inc[IX_PM_CRC]     = PM_CRC_CORRUPT;
        inc[IX_ESCAPE]     = SYNC_ESCAPE;
    end

    // reset low so a not-ready level present at release is no drop
    always_ff @(posedge REF_CLK) begin
        if (RESET) begin
            phy_rdy_ff <= 1'b0;
        end else begin
            phy_rdy_ff <= PHY_READY;
        end
    end

    assign start    = (st_ff == S_IDLE) & LOG_READ;
    assign clr_page = (st_ff == S_SUM) & clr_req_ff;
    assign clr_all  = BIST_ACTIVATE | clr_page;

    for (genvar g = 0; g < NUM_CNT; g++) begin : g_cnt
        if (IMPL[g]) begin : g_on
            // only power-on reset, link resets are not inputs
            always_ff @(posedge REF_CLK) begin
                if (RESET) begin
                    cnt_ff[g] <= '0;
                end else if (clr_all) begin
                    // an event in the clear cycle is kept
                    cnt_ff[g] <= inc[g] ? CNT_W'(1) : '0;
                end else if (inc[g] && !(&cnt_ff[g])) begin
                    cnt_ff[g] <= cnt_ff[g] + CNT_W'(1);
                end
            end
            // page shows values frozen at the request
            always_ff @(posedge REF_CLK) begin
                if (RESET) begin
                    snap_ff[g] <= '0;
                end else if (start) begin
                    snap_ff[g] <= cnt_ff[g];
                end
            end
        end else begin : g_off
            assign cnt_ff[g]  = '0;
            assign snap_ff[g] = '0;
        end
    end

    // vendor flag keeps the size code
    always_comb begin
        rec_id = {VENDOR_MASK[rec_ff], REP_SIZE, CNT_ID[rec_ff]};
        if (&snap_ff[rec_ff]) begin
            rec_val = '1;
        end else begin
            rec_val = REP_W'(snap_ff[rec_ff]);
        end
    end

    // value is two whole sixteen-bit words
    always_comb begin
        case (st_ff)
            S_REC: begin
                case (off_ff)
                    3'h0:    cur_byte = rec_id[7:0];
                    3'h1:    cur_byte = rec_id[15:8];
                    3'h2:    cur_byte = rec_val[7:0];
                    3'h3:    cur_byte = rec_val[15:8];
                    3'h4:    cur_byte = rec_val[23:16];
                    default: cur_byte = rec_val[31:24];
                endcase
            end
            S_SUM:   cur_byte = 8'h00 - sum_ff;
            // pad starts with the end marker
            S_PAD:   cur_byte = ID_END_MARK[7:0];
            default: cur_byte = 8'h00;
        endcase
    end

    always_ff @(posedge REF_CLK) begin
        if (RESET) begin
            st_ff      <= S_IDLE;
            idx_ff     <= '0;
            off_ff     <= '0;
            rec_ff     <= '0;
            clr_req_ff <= 1'b0;
            LOG_BUSY   <= 1'b0;
        end else begin
            idx_ff <= idx_ff + 9'h001;
            case (st_ff)
                S_IDLE: begin
                    idx_ff <= '0;
                    if (LOG_READ) begin
                        st_ff      <= S_HDR;
                        clr_req_ff <= LOG_FEATURES[LOG_CLR_BIT];
                        LOG_BUSY   <= 1'b1;
                    end
                end
                S_HDR: begin
                    if (idx_ff == HDR_LAST_BYTE) begin
                        off_ff <= '0;
                        rec_ff <= first_rec;
                        st_ff  <= (first_rec == REC_W'(NUM_CNT))
                                  ? S_PAD : S_REC;
                    end
                end
                S_REC: begin
                    off_ff <= off_ff + 3'h1;
                    if (off_ff == REC_LAST_OFF) begin
                        off_ff <= '0;
                        rec_ff <= nxt_rec;
                        if (nxt_rec == REC_W'(NUM_CNT)) begin
                            st_ff <= S_PAD;
                        end
                    end
                end
                S_PAD: begin
                    if (idx_ff == PAD_LAST_BYTE) begin
                        st_ff <= S_SUM;
                    end
                end
                S_SUM: begin
                    st_ff      <= S_IDLE;
                    clr_req_ff <= 1'b0;
                    LOG_BUSY   <= 1'b0;
                end
                default: begin
                    st_ff <= S_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (RESET || st_ff == S_IDLE) begin
            sum_ff <= '0;
        end else if (st_ff != S_SUM) begin
            sum_ff <= sum_ff + cur_byte;
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (RESET) begin
            PAGE_BYTE  <= '0;
            PAGE_VALID <= 1'b0;
            PAGE_LAST  <= 1'b0;
        end else begin
            PAGE_BYTE  <= cur_byte;
            PAGE_VALID <= (st_ff != S_IDLE);
            PAGE_LAST  <= (st_ff == S_SUM);
        end
    end

    // helper: position and sum of bytes seen at the outputs
    logic [8:0] out_pos_ff;
    logic [7:0] out_sum_ff;
    always_ff @(posedge REF_CLK) begin
        if (RESET || !PAGE_VALID) begin
            out_pos_ff <= '0;
            out_sum_ff <= '0;
        end else begin
            out_pos_ff <= out_pos_ff + 9'h001;
            out_sum_ff <= out_sum_ff + PAGE_BYTE;
        end
    end

    icrc_count_a: assert property (
        @(posedge REF_CLK) disable iff (RESET)
        (CMD_DONE && CMD_STATUS_ERR && CMD_ERROR_ICRC && !clr_all
         && !(&cnt_ff[IX_CMD_ICRC]))
        |=> cnt_ff[IX_CMD_ICRC] == $past(cnt_ff[IX_CMD_ICRC]) + CNT_W'(1))
        else $error("interface crc counter did not advance");

    escape_veto_a: assert property (
        @(posedge REF_CLK) disable iff (RESET)
        (IMPL[IX_H2D_DATA] && SYNC_ESCAPE && !clr_all)
        |=> $stable(cnt_ff[IX_H2D_DATA]))
        else $error("escaped frame was counted");

    sat_hold_a: assert property (
        @(posedge REF_CLK) disable iff (RESET)
        ((&cnt_ff[IX_SIG_FIS]) && !clr_all) |=> (&cnt_ff[IX_SIG_FIS]))
        else $error("saturated counter wrapped");

    bist_clear_a: assert property (
        @(posedge REF_CLK) disable iff (RESET)
        BIST_ACTIVATE |=> cnt_ff[IX_SIG_FIS] <= CNT_W'(1))
        else $error("counter not cleared by bist");

    phy_drop_a: assert property (
        @(posedge REF_CLK) disable iff (RESET)
        (IMPL[IX_PHY_DROP] && $fell(PHY_READY) && !clr_all && !$past(RESET)
         && !(&cnt_ff[IX_PHY_DROP]))
        |-> ##1 cnt_ff[IX_PHY_DROP]
            == $past(cnt_ff[IX_PHY_DROP]) + CNT_W'(1))
        else $error("ready drop not counted");

    page_stream_a: assert property (
        @(posedge REF_CLK) disable iff (RESET)
        (LOG_READ && !LOG_BUSY) |=> LOG_BUSY ##1 PAGE_VALID[*8])
        else $error("page bytes not streamed");

    checksum_a: assert property (
        @(posedge REF_CLK) disable iff (RESET)
        PAGE_LAST |-> (out_pos_ff == SUM_BYTE)
                      && (8'(out_sum_ff + PAGE_BYTE) == 8'h00))
        else $error("page checksum or length wrong");

    first_id_a: assert property (
        @(posedge REF_CLK) disable iff (RESET)
        (PAGE_VALID && out_pos_ff == 9'h004) |-> PAGE_BYTE == 8'h01
            ##1 PAGE_BYTE == {1'b0, REP_SIZE, 4'h0})
        else $error("first record identifier wrong");

    header_zero_a: assert property (
        @(posedge REF_CLK) disable iff (RESET)
        (PAGE_VALID && out_pos_ff < 9'h004) |-> PAGE_BYTE == 8'h00)
        else $error("reserved header byte not zero");

endmodule : phy_event_counters
`default_nettype wire

// [tb/host_link_model.sv]
// far-side link model issuing event strobes and phy ready
`default_nettype none
module host_link_model (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic [15:0] ev_mask,
    input  wire logic        ev_go,
    input  wire logic        drop,
    output var  logic [15:0] strobe,
    output var  logic        phy_ready
);
    timeunit 1ns;
    timeprecision 1ps;

    // clear frame as one pulse
    // strobes last one cycle only, never held over
    always @(posedge clk) begin
        strobe <= (rst || !ev_go) ? 16'h0000 : ev_mask;
    end

    // link stays up out of reset so no false drop
    always @(posedge clk) begin
        phy_ready <= rst || !drop;
    end
endmodule : host_link_model
`default_nettype wire

// [tb/testbench.sv]
// self-checking bench for the link event counter bank
`default_nettype none
`define CHK(nm, e, g) begin tests_run++; if ((e) !== (g)) begin n_fail++; \
    $display("mismatch %s exp %h got %h", nm, e, g); end end
module testbench
    import phy_counter_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int                 CNT_W = 8;
    localparam int                 MAXV  = 255;
    localparam logic [NUM_CNT-1:0] OPT   = 20'hff7fe;
    localparam logic [NUM_CNT-1:0] BUILT = OPT | MAND_MASK;

    logic        REF_CLK;
    logic        RESET;
    logic        LOG_READ;
    logic [7:0]  LOG_FEATURES;
    logic [7:0]  PAGE_BYTE;
    logic        PAGE_VALID;
    logic        PAGE_LAST;
    logic        LOG_BUSY;
    logic [15:0] ev_mask;
    logic        ev_go;
    logic        drop;
    logic [15:0] strobe;
    logic        phy_ready;
    int          exp_cnt [NUM_CNT];
    int          n_fail;
    int          tests_run;
    int          cyc;

    host_link_model link (.clk(REF_CLK), .rst(RESET), .ev_mask(ev_mask),
        .ev_go(ev_go), .drop(drop), .strobe(strobe), .phy_ready(phy_ready));

    phy_event_counters #(.CNT_W(CNT_W), .OPT_MASK(OPT)) dut (
        .REF_CLK(REF_CLK), .RESET(RESET), .CMD_DONE(strobe[0]),
        .CMD_STATUS_ERR(strobe[1]), .CMD_ERROR_ICRC(strobe[2]),
        .D2H_DATA_RERR(strobe[3]), .H2D_DATA_RERR_CRC(strobe[4]),
        .H2D_DATA_RERR_OTHER(strobe[5]), .D2H_NDATA_RERR(strobe[6]),
        .D2H_NDATA_RETRIED(strobe[7]), .H2D_NDATA_RERR_CRC(strobe[8]),
        .H2D_NDATA_RERR_OTHER(strobe[9]), .SYNC_ESCAPE(strobe[10]),
        .PHY_READY(phy_ready), .SIG_FIS_ACKED(strobe[11]),
        .PM_COLLISION(strobe[12]), .PM_SIG_FWD(strobe[13]),
        .PM_CRC_CORRUPT(strobe[14]), .BIST_ACTIVATE(strobe[15]),
        .LOG_READ(LOG_READ), .LOG_FEATURES(LOG_FEATURES),
        .PAGE_BYTE(PAGE_BYTE), .PAGE_VALID(PAGE_VALID),
        .PAGE_LAST(PAGE_LAST), .LOG_BUSY(LOG_BUSY));

    initial begin
        REF_CLK = 1'b0;
        forever #20 REF_CLK = ~REF_CLK;
    end

    task automatic give_verdict();
        if (n_fail == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : give_verdict

    always @(posedge REF_CLK) begin
        cyc++;
        if (cyc == 12000) begin
            n_fail++;
            give_verdict();
        end
    end

    // event strobes plus expected counter update
    task automatic fire(input logic [15:0] m, input logic d);
        logic [19:0] h;
        h = 20'h00000;
        if (m[0] && m[1] && m[2]) h[0] = 1'b1;
        h = h | ({20{m[3]}} & 20'h00006) | ({20{m[4]}} & 20'h0140a);
        h = h | ({20{m[5]}} & 20'h0280a) | ({20{m[6]}} & 20'h00030);
        h = h | ({20{m[6] && m[7]}} & 20'h00080);
        h = h | ({20{m[8]}} & 20'h04450) | ({20{m[9]}} & 20'h08850);
        h = h | {1'b0, m[14], m[13], m[12], 6'h00, m[11], d, 8'h00};
        if (m[10]) h = (h & ~20'h1fcfe) | 20'h80000;
        @(posedge REF_CLK);
        ev_mask <= m;
        ev_go <= 1'b1;
        drop <= d;
        @(posedge REF_CLK);
        ev_go <= 1'b0;
        drop <= 1'b0;
        if (m[15]) exp_cnt = '{default: 0};
        for (int i = 0; i < NUM_CNT; i++) begin
            if (h[i] && exp_cnt[i] < MAXV) exp_cnt[i]++;
        end
    endtask : fire

    // requests a page and compares every byte with the model
    task automatic read_page(input logic [7:0] feat);
        logic [7:0]  pg [512];
        logic [31:0] v;
        int          pos;
        int          sum;
        int          w;
        foreach (pg[b]) pg[b] = 8'h00;
        pos = 4;
        sum = 0;
        w = 0;
        for (int i = 0; i < NUM_CNT; i++) begin
            if (BUILT[i]) begin
                v = (exp_cnt[i] == MAXV) ? 32'hffffffff : 32'(exp_cnt[i]);
                {pg[pos+5], pg[pos+4], pg[pos+3], pg[pos+2], pg[pos+1],
                    pg[pos]} = {v, VENDOR_MASK[i], REP_SIZE, CNT_ID[i]};
                pos += 6;
            end
        end
        for (int b = 0; b < 511; b++) sum += pg[b];
        pg[511] = 8'(0 - sum);
        repeat (2) @(posedge REF_CLK);
        LOG_READ <= 1'b1;
        LOG_FEATURES <= feat;
        @(posedge REF_CLK);
        LOG_READ <= 1'b0;
        #1;
        while (PAGE_VALID !== 1'b1 && w < 8) begin
            @(posedge REF_CLK);
            #1;
            w++;
        end
        for (int b = 0; b < 512; b++) begin
            `CHK("page byte", pg[b], PAGE_BYTE)
            `CHK("page last", 1'(b == 511), PAGE_LAST)
            `CHK("busy", 1'(b != 511), LOG_BUSY)
            @(posedge REF_CLK);
            // a repeat request mid-page must be ignored
            LOG_READ <= (b == 100);
            #1;
        end
        `CHK("valid end", 1'b0, PAGE_VALID)
        if (feat[0]) exp_cnt = '{default: 0};
    endtask : read_page

    task automatic do_reset();
        RESET <= 1'b1;
        repeat (8) @(posedge REF_CLK);
        RESET <= 1'b0;
        exp_cnt = '{default: 0};
    endtask : do_reset

    localparam logic [15:0] TBL [16] = '{16'h0007, 16'h0003, 16'h0005,
        16'h0008, 16'h0010, 16'h0020, 16'h0040, 16'h00c0, 16'h0100,
        16'h0200, 16'h0800, 16'h1000, 16'h2000, 16'h4000, 16'h0450,
        16'h1660};

    initial begin
        RESET = 1'b1;
        LOG_READ = 1'b0;
        LOG_FEATURES = 8'h00;
        ev_mask = 16'h0000;
        ev_go = 1'b0;
        drop = 1'b0;
        n_fail = 0;
        tests_run = 0;
        cyc = 0;
        exp_cnt = '{default: 0};
        repeat (8) @(posedge REF_CLK);
        RESET <= 1'b0;
        read_page(8'h00);
        foreach (TBL[t]) begin
            fire(TBL[t], 1'b0);
            fire(TBL[t], 1'b0);
        end
        fire(16'h0000, 1'b1);
        read_page(8'h00);
        repeat (260) fire(16'h7bf8, 1'b1);
        read_page(8'h01);
        read_page(8'h00);
        fire(16'h0800, 1'b0);
        fire(16'h8008, 1'b0);
        read_page(8'h00);
        fire(16'h0800, 1'b0);
        do_reset();
        read_page(8'h00);
        give_verdict();
    end
endmodule : testbench
`default_nettype wire
